// ---- design/tpg_pkg.sv ----
// Package for the test-page port and probe control block
// Summary of operation
// - Reorder bit maps probe bus D4,D3,D2,D6,D5,D0,D1
// - Bit 6 starts 9-stage sequence generator
// - Bit 5 starts 15-stage sequence generator
// - Sequence transmits only after send command
// - Bits 4..0 select observable probe bus
// - Handshake enable low disables handshake lines
// - Enable bits 6..0 drive matching data pins
// - Pin enables act only with serial host
// - SPI or handshake UART limits pins D0..D4
// - Port I/O enable bit activates general I/O with serial host
// - Value bits drive pins whose enable set
// - Read returns live pins when I/O enabled
// - Secure clock on D1 removes D1 from I/O
// - Probe status reads selected probe bus
// - Pin enable at 33h, resets 80h
// - Pin value at 34h, resets 00h
// - Test select at 32h, resets 00h
// - Secure clock bit outputs secure clock on D1 with serial host
package tpg_pkg;
    localparam logic [5:0] TPG_ADDR_TEST_SEL   = 6'h32;
    localparam logic [5:0] TPG_ADDR_PIN_EN     = 6'h33;
    localparam logic [5:0] TPG_ADDR_PIN_VAL    = 6'h34;
    localparam logic [5:0] TPG_ADDR_PROBE_STAT = 6'h35;
    localparam logic [7:0] TPG_RST_TEST_SEL    = 8'h00;
    localparam logic [7:0] TPG_RST_PIN_EN      = 8'h80;
    localparam logic [7:0] TPG_RST_PIN_VAL     = 8'h00;
    localparam int         TPG_BIT_REORDER     = 7;
    localparam int         TPG_BIT_PRBS9       = 6;
    localparam int         TPG_BIT_PRBS15      = 5;
    localparam int         TPG_BIT_HS_EN       = 7;
    localparam int         TPG_BIT_IO_EN       = 7;
    localparam int         TPG_PROBE_SEL_W     = 5;
    localparam logic [8:0]  TPG_PRBS9_SEED     = 9'h1FF;
    localparam logic [14:0] TPG_PRBS15_SEED    = 15'h7FFF;

    typedef enum logic [1:0] {
        TPG_HOST_PARALLEL,
        TPG_HOST_SPI,
        TPG_HOST_UART,
        TPG_HOST_I2C
    } tpg_host_t;

    typedef enum {
        TPG_SEQ_IDLE,
        TPG_SEQ_ARMED,
        TPG_SEQ_SEND
    } tpg_seq_t;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tpg_bus_req_t;

    typedef struct packed {
        logic [6:0] d_out;
        logic [6:0] d_oe;
    } tpg_pins_t;

    typedef struct packed {
        logic [7:0]     test_sel;
        logic [7:0]     pin_en;
        logic [7:0]     pin_val;
        logic [7:0]     rdata;
        tpg_pins_t      pins;
        logic           hs_lines_en;
        logic [8:0]     lfsr9;
        logic [14:0]    lfsr15;
        tpg_seq_t       seq;
        logic           tx_bit;
        logic           tx_valid;
    } tpg_state_t;
endpackage : tpg_pkg

// ---- design/tpg_port_ctrl.sv ----
// Test-page control: probe mapping, sequence generators, general port I/O
module tpg_port_ctrl
    import tpg_pkg::*;
#(
    parameter int NUM_PROBES = 32
) (
    input  wire logic                 ref_clk,        // 250 MHz clock
    input  wire logic                 sys_rst,        // Synchronous reset, high
    input  wire tpg_bus_req_t         bus_req,        // Register access request
    output logic [7:0]                rdata,          // Read data, cycle after read
    input  wire logic [NUM_PROBES*8-1:0] probe_buses, // All internal probe buses
    input  wire tpg_host_t            host_if,        // Active host interface
    input  wire logic                 secure_clock_on_pin1, // Secure clock to D1
    input  wire logic                 secure_clk,     // Secure-module clock level
    input  wire logic                 send_cmd,       // Send command pulse
    input  wire logic                 tx_stop,        // Transmit end / mode abort
    input  wire logic [6:0]           d_in,           // Data pin levels
    output logic [6:0]                d_out,          // Data pin drive levels
    output logic [6:0]                d_oe,           // Data pin output enables
    output logic                      uart_hs_en,     // Handshake lines enabled
    output logic                      tx_bit,         // Sequence transmit bit
    output logic                      tx_valid        // Sequence transmit active
);

    tpg_state_t q;
    tpg_state_t next_q;

    function automatic logic [7:0] probe_pick(input logic [NUM_PROBES*8-1:0] buses, input logic [4:0] sel);
        logic [7:0] r;
        r = 8'h00;
        if (int'(sel) < NUM_PROBES) begin
            r = buses[int'(sel)*8 +: 8];
        end
        return r;
    endfunction : probe_pick

    logic [7:0] probe_now;
    logic       serial_host;
    logic [6:0] usable;
    logic [6:0] mapped;
    logic       io_on;

    always_comb begin
        probe_now   = probe_pick(probe_buses, q.test_sel[TPG_PROBE_SEL_W-1:0]);
        serial_host = (host_if != TPG_HOST_PARALLEL);
        usable      = 7'h7F;
        if (host_if == TPG_HOST_SPI || (host_if == TPG_HOST_UART && q.pin_en[TPG_BIT_HS_EN])) begin
            usable = 7'h1F;
        end
        if (secure_clock_on_pin1) begin
            usable[1] = 1'b0;
        end
        io_on = serial_host && q.pin_val[TPG_BIT_IO_EN];
        // Probe bits 0 to 6 land on D4, D3, D2, D6, D5, D0, D1 in that order
        if (q.test_sel[TPG_BIT_REORDER]) begin
            mapped = {probe_now[3], probe_now[4], probe_now[0], probe_now[1],
                      probe_now[2], probe_now[6], probe_now[5]};
        end else begin
            mapped = probe_now[6:0];
        end
    end

    always_comb begin
        next_q = q;
        next_q.rdata = 8'h00;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                TPG_ADDR_TEST_SEL: next_q.test_sel = bus_req.wdata;
                TPG_ADDR_PIN_EN:   next_q.pin_en   = bus_req.wdata;
                TPG_ADDR_PIN_VAL:  next_q.pin_val  = bus_req.wdata;
                default: ;
            endcase
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                TPG_ADDR_TEST_SEL:   next_q.rdata = q.test_sel;
                TPG_ADDR_PIN_EN:     next_q.rdata = q.pin_en;
                TPG_ADDR_PIN_VAL:    next_q.rdata = io_on ? {q.pin_val[TPG_BIT_IO_EN], d_in} : q.pin_val;
                TPG_ADDR_PROBE_STAT: next_q.rdata = probe_now;
                default:             next_q.rdata = 8'h00;
            endcase
        end
        next_q.hs_lines_en = q.pin_en[TPG_BIT_HS_EN];
        // Pin drivers: general I/O first, probe mapping when I/O is off
        next_q.pins.d_oe  = 7'h00;
        next_q.pins.d_out = 7'h00;
        if (serial_host) begin
            next_q.pins.d_oe  = q.pin_en[6:0] & usable;
            next_q.pins.d_out = io_on ? q.pin_val[6:0] : mapped;
        end
        if (secure_clock_on_pin1 && serial_host) begin
            next_q.pins.d_oe[1]  = 1'b1;
            next_q.pins.d_out[1] = secure_clk;
        end
        // Generators hold the seed while idle or armed so a send always starts from the seed state
        next_q.lfsr9  = {q.lfsr9[7:0], q.lfsr9[8] ^ q.lfsr9[4]};
        next_q.lfsr15 = {q.lfsr15[13:0], q.lfsr15[14] ^ q.lfsr15[13]};
        next_q.tx_bit   = 1'b0;
        next_q.tx_valid = 1'b0;
        unique case (q.seq)
            TPG_SEQ_IDLE: begin
                next_q.lfsr9  = TPG_PRBS9_SEED;
                next_q.lfsr15 = TPG_PRBS15_SEED;
                if (q.test_sel[TPG_BIT_PRBS9] || q.test_sel[TPG_BIT_PRBS15]) begin
                    next_q.seq = TPG_SEQ_ARMED;
                end
            end
            TPG_SEQ_ARMED: begin
                next_q.lfsr9  = TPG_PRBS9_SEED;
                next_q.lfsr15 = TPG_PRBS15_SEED;
                if (!(q.test_sel[TPG_BIT_PRBS9] || q.test_sel[TPG_BIT_PRBS15])) begin
                    next_q.seq = TPG_SEQ_IDLE;
                end else if (send_cmd) begin
                    next_q.seq = TPG_SEQ_SEND;
                end
            end
            TPG_SEQ_SEND: begin
                next_q.tx_valid = 1'b1;
                next_q.tx_bit   = q.test_sel[TPG_BIT_PRBS9] ? q.lfsr9[8] : q.lfsr15[14];
                if (tx_stop || !(q.test_sel[TPG_BIT_PRBS9] || q.test_sel[TPG_BIT_PRBS15])) begin
                    next_q.seq      = TPG_SEQ_IDLE;
                    next_q.tx_valid = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q          <= '0;
            q.test_sel <= TPG_RST_TEST_SEL;
            q.pin_en   <= TPG_RST_PIN_EN;
            q.pin_val  <= TPG_RST_PIN_VAL;
            q.hs_lines_en <= 1'b1;
            q.lfsr9    <= TPG_PRBS9_SEED;
            q.lfsr15   <= TPG_PRBS15_SEED;
            q.seq      <= TPG_SEQ_IDLE;
        end else begin
            q <= next_q;
        end
    end

    assign rdata      = q.rdata;
    assign d_out      = q.pins.d_out;
    assign d_oe       = q.pins.d_oe;
    assign uart_hs_en = q.hs_lines_en;
    assign tx_bit     = q.tx_bit;
    assign tx_valid   = q.tx_valid;

endmodule : tpg_port_ctrl

// ---- dv/testbench.sv ----
// Self-checking bench for the test-page port block
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tpg_pkg::*;
    logic ref_clk = 0, sys_rst = 1, secure_clock_on_pin1 = 0, secure_clk = 0, send_cmd = 0, tx_stop = 0;
    tpg_bus_req_t bus_req = '0;
    tpg_host_t host_if = TPG_HOST_SPI;
    logic [255:0] probe_buses = '0;
    logic [6:0] d_in, d_out, d_oe, board = 7'h2A;
    logic [7:0] rdata;
    logic uart_hs_en, tx_bit, tx_valid;
    int err_total = 0, comparisons = 0;
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) secure_clk <= ~secure_clk;
    tpg_port_ctrl tpg_port_ctrl_i (
        .ref_clk              (ref_clk),
        .sys_rst              (sys_rst),
        .bus_req              (bus_req),
        .rdata                (rdata),
        .probe_buses          (probe_buses),
        .host_if              (host_if),
        .secure_clock_on_pin1 (secure_clock_on_pin1),
        .secure_clk           (secure_clk),
        .send_cmd             (send_cmd),
        .tx_stop              (tx_stop),
        .d_in                 (d_in),
        .d_out                (d_out),
        .d_oe                 (d_oe),
        .uart_hs_en           (uart_hs_en),
        .tx_bit               (tx_bit),
        .tx_valid             (tx_valid)
    );
    tpg_pin_model tpg_pin_model_i (.d_out(d_out), .d_oe(d_oe), .board(board), .d_in(d_in));
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk) bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk) bus_req.wr <= 1'b0;
    endtask : wr
    task automatic chk_rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge ref_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk) bus_req.rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : chk_rd
    task automatic settle;
        repeat (3) @(negedge ref_clk);
    endtask : settle
    task automatic t_port_io;
        wr(TPG_ADDR_PIN_EN, 8'h7D);
        wr(TPG_ADDR_PIN_VAL, 8'hD5);
        chk_rd(TPG_ADDR_PIN_VAL, 8'hB7);
        `CHK(d_oe, 7'h1D)
        `CHK(uart_hs_en, 1'b0)
        @(posedge ref_clk) secure_clock_on_pin1 <= 1'b1;
        settle;
        `CHK(d_oe, 7'h1F)
        @(posedge ref_clk) secure_clock_on_pin1 <= 1'b0;
        host_if <= TPG_HOST_UART;
        settle;
        `CHK(d_oe, 7'h7D)
        @(posedge ref_clk) host_if <= TPG_HOST_PARALLEL;
        settle;
        `CHK(d_oe, 7'h00)
        @(posedge ref_clk) host_if <= TPG_HOST_SPI;
        wr(TPG_ADDR_PIN_VAL, 8'h2A);
        chk_rd(TPG_ADDR_PIN_VAL, 8'h2A);
    endtask : t_port_io
    task automatic t_probe;
        @(posedge ref_clk) probe_buses[39:24] <= 16'hC35A;
        wr(TPG_ADDR_TEST_SEL, 8'h83);
        chk_rd(TPG_ADDR_PROBE_STAT, 8'h5A);
        `CHK(d_out, 7'h6A)
        wr(TPG_ADDR_PROBE_STAT, 8'hFF);
        wr(TPG_ADDR_TEST_SEL, 8'h04);
        chk_rd(TPG_ADDR_PROBE_STAT, 8'hC3);
        `CHK(d_out, 7'h43)
    endtask : t_probe
    // An all-ones seed shows as a run of ones as long as the generator
    task automatic t_prbs(input logic [7:0] mode, input int ones);
        int n;
        wr(TPG_ADDR_TEST_SEL, mode);
        settle;
        `CHK(tx_valid, 1'b0)
        @(posedge ref_clk) send_cmd <= 1'b1;
        @(posedge ref_clk) send_cmd <= 1'b0;
        for (n = 0; n < 10 && tx_valid !== 1'b1; n++) @(negedge ref_clk);
        for (n = 0; n < 20 && tx_bit === 1'b1; n++) @(negedge ref_clk);
        `CHK(n, ones)
        `CHK(tx_valid, 1'b1)
        @(posedge ref_clk) tx_stop <= 1'b1;
        @(posedge ref_clk) tx_stop <= 1'b0;
        #1 `CHK(tx_valid, 1'b0)
        wr(TPG_ADDR_TEST_SEL, 8'h00);
    endtask : t_prbs
    task automatic give_verdict;
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        chk_rd(TPG_ADDR_TEST_SEL, 8'h00);
        chk_rd(TPG_ADDR_PIN_EN, 8'h80);
        chk_rd(TPG_ADDR_PIN_VAL, 8'h00);
        `CHK(uart_hs_en, 1'b1)
        `CHK(d_oe, 7'h00)
        t_port_io;
        t_probe;
        t_prbs(8'h40, 9);
        t_prbs(8'h20, 15);
        t_prbs(8'h60, 9);
        give_verdict;
    end
    initial begin
        #20000;
        err_total++;
        give_verdict;
    end
endmodule : testbench

// ---- dv/tpg_pin_model.sv ----
// Board-side model of the seven data pins
module tpg_pin_model (
    input  wire logic [6:0] d_out, // Block drive levels
    input  wire logic [6:0] d_oe,  // Block drive enables
    input  wire logic [6:0] board, // Board drive where the block is off
    output logic      [6:0] d_in   // Resolved pin levels
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board logic always drives released pins, so no pin floats
    always_comb d_in = (d_out & d_oe) | (board & ~d_oe);
endmodule : tpg_pin_model

// ---- dv/tpg_port_ctrl_assertions.sv ----
// Checker for the test-page port block
module tpg_port_chk
    import tpg_pkg::*;
#(
    parameter int NUM_PROBES = 32
) (
    input wire logic                    ref_clk,              // Clock
    input wire logic                    sys_rst,              // Reset, high
    input wire logic                    secure_clock_on_pin1, // Secure clock select
    input wire logic                    secure_clk,           // Secure clock level
    input wire logic                    send_cmd,             // Send command
    input wire logic                    tx_stop,              // Transmit stop
    input wire tpg_bus_req_t            bus_req,              // Register request
    input wire tpg_host_t               host_if,              // Host kind
    input wire logic [NUM_PROBES*8-1:0] probe_buses,          // Probe buses
    input wire logic [6:0]              d_in,                 // Pin levels
    input wire logic [6:0]              d_out,                // Pin drive levels
    input wire logic [6:0]              d_oe,                 // Pin drive enables
    input wire logic [7:0]              rdata,                // Read data
    input wire logic                    uart_hs_en,           // Handshake enable
    input wire logic                    tx_bit,               // Sequence bit
    input wire logic                    tx_valid              // Sequence valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_rdata_idle: assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("rdata not idle");
    a_parallel_quiet: assert property ($past(host_if) == TPG_HOST_PARALLEL |-> d_oe == 7'h00)
        else $error("drive with parallel host");
    a_hs_follows: assert property (bus_req.wr && bus_req.addr == TPG_ADDR_PIN_EN |-> ##2
        uart_hs_en == $past(bus_req.wdata[7], 2)) else $error("handshake enable wrong");
    a_narrow_port: assert property ($past(host_if) == TPG_HOST_SPI || ($past(host_if) == TPG_HOST_UART
        && uart_hs_en) |-> d_oe[6:5] == 2'b00) else $error("D5 or D6 driven");
    a_secure_d1: assert property ($past(secure_clock_on_pin1) && $past(host_if) != TPG_HOST_PARALLEL
        |-> d_oe[1] && d_out[1] == $past(secure_clk)) else $error("D1 not secure clock");
    a_tx_after_send: assert property ($rose(tx_valid) |-> $past(send_cmd, 2) || $past(send_cmd, 3))
        else $error("transmit without send");
    a_seed_first: assert property ($rose(tx_valid) |-> tx_bit) else $error("first bit not one");
    a_stop_ends: assert property (tx_stop |-> ##2 !tx_valid) else $error("transmit not stopped");
    cover property ($rose(tx_valid));
    cover property (bus_req.rd && bus_req.addr == TPG_ADDR_PROBE_STAT);
    cover property ($past(secure_clock_on_pin1) && d_oe[1]);
endmodule : tpg_port_chk
bind tpg_port_ctrl tpg_port_chk #(
    .NUM_PROBES(NUM_PROBES)
) tpg_port_chk_i (
    .ref_clk              (ref_clk),
    .sys_rst              (sys_rst),
    .secure_clock_on_pin1 (secure_clock_on_pin1),
    .secure_clk           (secure_clk),
    .send_cmd             (send_cmd),
    .tx_stop              (tx_stop),
    .bus_req              (bus_req),
    .host_if              (host_if),
    .probe_buses          (probe_buses),
    .d_in                 (d_in),
    .d_out                (d_out),
    .d_oe                 (d_oe),
    .rdata                (rdata),
    .uart_hs_en           (uart_hs_en),
    .tx_bit               (tx_bit),
    .tx_valid             (tx_valid)
);
